//--- core/ttssl_core.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ttssl_core
  import ttssl_pkg::*;
#(
  parameter int AXI_ADDR_W = 12,
  parameter int TXCLK_PERIOD_NS = TXCLK_PERIOD_NS_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // AXI4-Lite register slave
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Backplane and transmit pins
  input wire logic tx_clock_in,
  input wire logic tx_sync_pin_in,
  output logic tx_sync_pin_out,
  output logic tx_sync_pin_oe,
  input wire logic highspeed_sync_pin,
  input wire logic backplane_tx_serial,
  input wire logic rx_loop_serial,
  output logic tx_line_data,
  output logic tx_clock_loss_pin,
  output logic highspeed_clock_rate_sel,
  // Device interrupt
  input wire logic other_irq_pending,
  output logic host_alert_n
);
  localparam int LOSS_TIME_NS = LOSS_PERIODS * TXCLK_PERIOD_NS;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int LOSS_CNT_W = $clog2(LOSS_CYCLES + 1);
  localparam logic [LOSS_CNT_W-1:0] LOSS_LIMIT = LOSS_CNT_W'(LOSS_CYCLES);

  function automatic logic [4:0] chan_of(input logic [7:0] pos);
    logic [7:0] off;
    off = pos - SECOND_BIT;
    return off[CHAN_SHIFT+4:CHAN_SHIFT];
  endfunction

  function automatic logic sig_frame(input logic [4:0] fr);
    return (int'(fr) % SIG_FRAME_SPACING) == (SIG_FRAME_SPACING - 1);
  endfunction

  function automatic logic idx_known(input logic [IDX_W-1:0] idx);
    case (idx)
      IDX_TX_IO_CONFIG, IDX_TX_LATCHED_STATUS, IDX_TX_REALTIME_STATUS,
      IDX_TX_INTERRUPT_MASK, IDX_CHAN_LOOPBACK_LO, IDX_CHAN_LOOPBACK_MID,
      IDX_CHAN_LOOPBACK_HI, IDX_TX_CONTROL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ttssl_iocfg_type cfg_reg;
  ttssl_pos_type pos_reg;
  logic [7:0] status_reg, mask_reg, ctrl_reg;
  logic [23:0] loop_en_reg;
  logic [PIN_COUNT-1:0] sync1_reg, sync2_reg, sync3_reg, pin_stable_reg;
  logic [PIN_COUNT-1:0] pins_in;
  logic clk_prev_reg, loss_reg, loss_prev_reg;
  logic [LOSS_CNT_W-1:0] idle_cnt_reg;
  logic [3:0] zero_run_reg;
  logic aw_free_reg, w_free_reg, ar_free_reg, bvalid_reg, rvalid_reg;
  logic [IDX_W-1:0] wr_idx_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic sync_out_reg, sync_oe_reg, line_data_reg, loss_pin_reg, rate_reg, alert_n_reg;

  // Pin synchronisers; a level counts once stages two and three agree.
  assign pins_in = {rx_loop_serial, backplane_tx_serial, highspeed_sync_pin,
                    tx_sync_pin_in, tx_clock_in};
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
        sync1_reg[g] <= 1'b0;
        sync2_reg[g] <= 1'b0;
        sync3_reg[g] <= 1'b0;
        pin_stable_reg[g] <= 1'b0;
      end else begin
        sync1_reg[g] <= pins_in[g];
        sync2_reg[g] <= sync1_reg[g];
        sync3_reg[g] <= sync2_reg[g];
        if (sync2_reg[g] == sync3_reg[g]) begin
          pin_stable_reg[g] <= sync3_reg[g];
        end
      end
    end
  end

  logic clk_now, clk_toggle, bit_edge;
  assign clk_now = pin_stable_reg[PIN_TXCLK];
  assign clk_toggle = clk_now != clk_prev_reg;
  assign bit_edge = cfg_reg.clock_invert ? (clk_prev_reg && !clk_now) : (!clk_prev_reg && clk_now);

  // Loss of clock: no transition for LOSS_PERIODS periods of TXCLK_PERIOD_NS, both fixed by parameter.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clk_prev_reg <= 1'b0;
      idle_cnt_reg <= '0;
      loss_reg <= 1'b0;
      loss_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= clk_now;
      loss_prev_reg <= loss_reg;
      if (clk_toggle) begin
        idle_cnt_reg <= '0;
        loss_reg <= 1'b0;
      end else if (idle_cnt_reg == LOSS_LIMIT) begin
        loss_reg <= 1'b1;
      end else begin
        idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
    end
  end

  logic sync_level, hs_level, align_frame, align_mf, wrap, mf_evt, slc_evt;
  logic [4:0] mf_last;
  assign sync_level = pin_stable_reg[PIN_TXSYNC] ^ cfg_reg.sync_invert;
  assign hs_level = pin_stable_reg[PIN_HIGHSPEED_SYNC_PIN] ^ cfg_reg.hs_sync_invert;
  assign align_frame = (!cfg_reg.sync_is_output && sync_level) || hs_level;
  assign align_mf = hs_level && cfg_reg.hs_mf_mode;
  assign mf_last = ctrl_reg[CTRL_D4_MODE] ? MF_LAST_D4 : MF_LAST_ESF;
  assign wrap = align_frame || (pos_reg.bit_pos == LAST_BIT);
  // Greater-or-equal, so that a switch to the shorter framing wraps at the next frame end.
  assign mf_evt = bit_edge && wrap && (align_mf || pos_reg.frame >= mf_last);
  assign slc_evt = bit_edge && wrap && ctrl_reg[CTRL_SLC_EN] &&
                   (align_mf || pos_reg.slc_frame == SLC_LAST);

  // Bit, frame and 72-frame position, realigned by sync inputs.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pos_reg <= '0;
    end else if (bit_edge) begin
      if (wrap) begin
        pos_reg.bit_pos <= FIRST_BIT;
        if (align_mf || pos_reg.frame >= mf_last) begin
          pos_reg.frame <= '0;
        end else begin
          pos_reg.frame <= pos_reg.frame + 1'b1;
        end
        if (align_mf || pos_reg.slc_frame == SLC_LAST) begin
          pos_reg.slc_frame <= '0;
        end else begin
          pos_reg.slc_frame <= pos_reg.slc_frame + 1'b1;
        end
      end else begin
        pos_reg.bit_pos <= pos_reg.bit_pos + 1'b1;
      end
    end
  end

  logic loop_sel, line_bit, dens_evt, sync_pulse;
  assign loop_sel = (pos_reg.bit_pos != FIRST_BIT) && loop_en_reg[chan_of(pos_reg.bit_pos)];
  assign line_bit = loop_sel ? pin_stable_reg[PIN_RXDATA] : pin_stable_reg[PIN_BPDATA];
  // Only the fifteen-zero run is checked; the sliding ones-density window is not.
  assign dens_evt = bit_edge && !line_bit && (zero_run_reg == DENSITY_MAX_ZEROS);
  assign sync_pulse = cfg_reg.sync_mf_mode ?
      (pos_reg.frame == '0 && pos_reg.bit_pos == FIRST_BIT) :
      (pos_reg.bit_pos == FIRST_BIT ||
       (cfg_reg.sync_double && sig_frame(pos_reg.frame) && pos_reg.bit_pos == SECOND_BIT));

  // Line data, density run and sync output, all advanced on the bit edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_data_reg <= 1'b0;
      zero_run_reg <= '0;
      sync_out_reg <= 1'b0;
    end else if (bit_edge) begin
      line_data_reg <= line_bit;
      if (line_bit) begin
        zero_run_reg <= '0;
      end else if (zero_run_reg != DENSITY_MAX_ZEROS) begin
        zero_run_reg <= zero_run_reg + 1'b1;
      end
      sync_out_reg <= sync_pulse ^ cfg_reg.sync_invert;
    end
  end

  // AXI4-Lite handshakes; the write waits until any response is taken.
  logic wr_fire, ar_take, clr_hit;
  logic [IDX_W-1:0] rd_idx;
  assign wr_fire = !aw_free_reg && !w_free_reg && !bvalid_reg;
  assign ar_take = s_axi_arvalid && ar_free_reg;
  assign rd_idx = s_axi_araddr[IDX_W+1:2];
  assign clr_hit = wr_fire && wstrb0_reg && (wr_idx_reg == IDX_TX_LATCHED_STATUS);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      aw_free_reg <= 1'b1;
      w_free_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_idx_reg <= '0;
      wdata_reg <= REG_RESET;
      wstrb0_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && aw_free_reg) begin
        aw_free_reg <= 1'b0;
        wr_idx_reg <= s_axi_awaddr[IDX_W+1:2];
      end
      if (s_axi_wvalid && w_free_reg) begin
        w_free_reg <= 1'b0;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_free_reg <= 1'b1;
        w_free_reg <= 1'b1;
        bvalid_reg <= 1'b1;
        bresp_reg <= idx_known(wr_idx_reg) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Software-written registers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg <= REG_RESET;
      mask_reg <= REG_RESET;
      ctrl_reg <= REG_RESET;
      loop_en_reg <= '0;
    end else if (wr_fire && wstrb0_reg) begin
      case (wr_idx_reg)
        IDX_TX_IO_CONFIG: cfg_reg <= wdata_reg;
        IDX_TX_INTERRUPT_MASK: mask_reg <= wdata_reg & STATUS_USED;
        IDX_TX_CONTROL: ctrl_reg <= wdata_reg & CTRL_USED;
        IDX_CHAN_LOOPBACK_LO: loop_en_reg[7:0] <= wdata_reg;
        IDX_CHAN_LOOPBACK_MID: loop_en_reg[15:8] <= wdata_reg;
        IDX_CHAN_LOOPBACK_HI: loop_en_reg[23:16] <= wdata_reg;
        default: ;
      endcase
    end
  end

  // Latched status: a new event in the cycle of its clear wins.
  logic [7:0] set_vec, clr_vec;
  assign set_vec = {3'h0, slc_evt, dens_evt, mf_evt, !loss_reg && loss_prev_reg,
                    loss_reg && !loss_prev_reg};
  assign clr_vec = clr_hit ? wdata_reg : 8'h00;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_reg <= REG_RESET;
    end else begin
      status_reg <= ((status_reg & ~clr_vec) | set_vec) & STATUS_USED;
    end
  end

  // Reads are captured once, so the value holds steady until rready.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ar_free_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= REG_RESET;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      ar_free_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= idx_known(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      case (rd_idx)
        IDX_TX_IO_CONFIG: rdata_reg <= cfg_reg;
        IDX_TX_LATCHED_STATUS: rdata_reg <= status_reg;
        IDX_TX_REALTIME_STATUS: rdata_reg <= {7'h00, loss_reg};
        IDX_TX_INTERRUPT_MASK: rdata_reg <= mask_reg;
        IDX_TX_CONTROL: rdata_reg <= ctrl_reg;
        IDX_CHAN_LOOPBACK_LO: rdata_reg <= loop_en_reg[7:0];
        IDX_CHAN_LOOPBACK_MID: rdata_reg <= loop_en_reg[15:8];
        IDX_CHAN_LOOPBACK_HI: rdata_reg <= loop_en_reg[23:16];
        default: rdata_reg <= REG_RESET;
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      ar_free_reg <= 1'b1;
    end
  end

  // Pin-side outputs and the alert.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync_oe_reg <= 1'b0;
      loss_pin_reg <= 1'b0;
      rate_reg <= 1'b0;
      alert_n_reg <= 1'b1;
    end else begin
      sync_oe_reg <= cfg_reg.sync_is_output;
      loss_pin_reg <= loss_reg && ctrl_reg[CTRL_LOSS_PIN_EN];
      rate_reg <= cfg_reg.hs_rate_high;
      alert_n_reg <= !((|(status_reg & mask_reg)) || other_irq_pending);
    end
  end

  assign s_axi_awready = aw_free_reg;
  assign s_axi_wready = w_free_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = ar_free_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rdata_reg};
  assign tx_sync_pin_out = sync_out_reg;
  assign tx_sync_pin_oe = sync_oe_reg;
  assign tx_line_data = line_data_reg;
  assign tx_clock_loss_pin = loss_pin_reg;
  assign highspeed_clock_rate_sel = rate_reg;
  assign host_alert_n = alert_n_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence seq_clear_write(int b);
    clr_hit && wdata_reg[b];
  endsequence
  sequence seq_frame_start;
    bit_edge && cfg_reg.sync_is_output && !cfg_reg.sync_mf_mode;
  endsequence

  chk_w1c_clears: assert property (
    seq_clear_write(ST_MULTIFRAME) ##0 !mf_evt |=> !status_reg[ST_MULTIFRAME])
    else $error("latched bit not cleared by a one");
  chk_zero_keeps: assert property (
    clr_hit && !wdata_reg[ST_CLOCK_LOSS] && status_reg[ST_CLOCK_LOSS] |=> status_reg[ST_CLOCK_LOSS])
    else $error("zero write changed a latched bit");
  chk_set_wins: assert property (
    seq_clear_write(ST_DENSITY) ##0 dens_evt |=> status_reg[ST_DENSITY])
    else $error("event lost against a clear");
  chk_unused_zero: assert property (
    (status_reg & ~STATUS_USED) == 8'h00)
    else $error("unused status bits set");
  chk_alert_low: assert property (
    (|(status_reg & mask_reg)) |=> !host_alert_n)
    else $error("alert not asserted for unmasked bit");
  chk_alert_release: assert property (
    !(|(status_reg & mask_reg)) && !other_irq_pending |=> host_alert_n)
    else $error("alert held with nothing pending");
  chk_loss_sets: assert property (
    $rose(loss_reg) |=> status_reg[ST_CLOCK_LOSS])
    else $error("clock loss not latched");
  chk_loss_pin: assert property (
    loss_reg && ctrl_reg[CTRL_LOSS_PIN_EN] |=> tx_clock_loss_pin)
    else $error("loss pin dropped during loss");
  chk_restored_sets: assert property (
    $fell(loss_reg) |=> status_reg[ST_CLOCK_RESTORED])
    else $error("clock restore not latched");
  chk_mf_event: assert property (
    mf_evt |=> status_reg[ST_MULTIFRAME])
    else $error("multiframe event not latched");
  chk_slc_event: assert property (
    slc_evt |=> status_reg[ST_SLC] ##0 ctrl_reg[CTRL_SLC_EN])
    else $error("slc event not latched");
  chk_density_event: assert property (
    dens_evt |=> status_reg[ST_DENSITY])
    else $error("density violation not latched");
  chk_loop_mux: assert property (
    bit_edge && loop_sel |=> tx_line_data == $past(pin_stable_reg[PIN_RXDATA]))
    else $error("loopback channel not sourced from receive data");
  chk_sync_oe: assert property (
    ##1 tx_sync_pin_oe == $past(cfg_reg.sync_is_output))
    else $error("sync enable does not follow direction");
  chk_frame_pulse: assert property (
    seq_frame_start ##0 pos_reg.bit_pos == FIRST_BIT |=> tx_sync_pin_out != $past(cfg_reg.sync_invert))
    else $error("frame sync pulse missing");
  chk_double_width: assert property (
    seq_frame_start ##0 cfg_reg.sync_double && sig_frame(pos_reg.frame) &&
    pos_reg.bit_pos == SECOND_BIT |=> tx_sync_pin_out != $past(cfg_reg.sync_invert))
    else $error("double-wide sync pulse missing");
  chk_read_stable: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved during read");
endmodule // ttssl_core
`default_nettype wire

//--- core/ttssl_pkg.sv
package ttssl_pkg;
  localparam int IDX_W = 10;
  localparam logic [IDX_W-1:0] IDX_TX_IO_CONFIG = 10'h184;
  localparam logic [IDX_W-1:0] IDX_TX_LATCHED_STATUS = 10'h190;
  localparam logic [IDX_W-1:0] IDX_TX_REALTIME_STATUS = 10'h191;
  localparam logic [IDX_W-1:0] IDX_TX_INTERRUPT_MASK = 10'h1A0;
  localparam logic [IDX_W-1:0] IDX_CHAN_LOOPBACK_LO = 10'h1D0;
  localparam logic [IDX_W-1:0] IDX_CHAN_LOOPBACK_MID = 10'h1D1;
  localparam logic [IDX_W-1:0] IDX_CHAN_LOOPBACK_HI = 10'h1D2;
  localparam logic [IDX_W-1:0] IDX_TX_CONTROL = 10'h1F0;
  localparam int ST_CLOCK_LOSS = 0;
  localparam int ST_CLOCK_RESTORED = 1;
  localparam int ST_MULTIFRAME = 2;
  localparam int ST_DENSITY = 3;
  localparam int ST_SLC = 4;
  localparam logic [7:0] STATUS_USED = 8'h1F;
  localparam logic [7:0] CTRL_USED = 8'h07;
  localparam int CTRL_LOSS_PIN_EN = 0;
  localparam int CTRL_SLC_EN = 1;
  localparam int CTRL_D4_MODE = 2;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] LAST_BIT = 8'hC0;
  localparam logic [7:0] FIRST_BIT = 8'h00;
  localparam logic [7:0] SECOND_BIT = 8'h01;
  localparam int CHAN_SHIFT = 3;
  localparam logic [4:0] MF_LAST_D4 = 5'h0B;
  localparam logic [4:0] MF_LAST_ESF = 5'h17;
  localparam logic [6:0] SLC_LAST = 7'h47;
  localparam int SIG_FRAME_SPACING = 6;
  localparam logic [3:0] DENSITY_MAX_ZEROS = 4'hF;
  localparam int MCLK_PERIOD_NS = 10;
  localparam int TXCLK_PERIOD_NS_DEF = 648;
  localparam int LOSS_PERIODS = 3;
  localparam int PIN_TXCLK = 0;
  localparam int PIN_TXSYNC = 1;
  localparam int PIN_HIGHSPEED_SYNC_PIN = 2;
  localparam int PIN_BPDATA = 3;
  localparam int PIN_RXDATA = 4;
  localparam int PIN_COUNT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef struct packed {
    logic clock_invert;
    logic sync_invert;
    logic hs_sync_invert;
    logic hs_rate_high;
    logic hs_mf_mode;
    logic sync_is_output;
    logic sync_double;
    logic sync_mf_mode;
  } ttssl_iocfg_type;
  typedef struct packed {
    logic [7:0] bit_pos;
    logic [4:0] frame;
    logic [6:0] slc_frame;
  } ttssl_pos_type;
endpackage

//--- testbench/ttssl_backplane_model.sv
`timescale 1ns/10ps
`default_nettype none
module ttssl_backplane_model (
  // Bench control
  input wire logic run,
  input wire logic bp_level,
  input wire logic rx_level,
  // Backplane pins
  output logic tx_clock_in,
  output logic backplane_tx_serial,
  output logic rx_loop_serial
);
  // A stopped clock holds its level, which is what a failed source looks like.
  initial begin
    tx_clock_in = 1'b0;
    forever begin
      #80;
      if (run) begin
        tx_clock_in = ~tx_clock_in;
      end
    end
  end
  // Data moves on the falling edge so it is settled at the rising sampling edge.
  initial begin
    backplane_tx_serial = 1'b1;
    rx_loop_serial = 1'b0;
    forever begin
      @(negedge tx_clock_in);
      backplane_tx_serial = bp_level;
      rx_loop_serial = rx_level;
    end
  end
endmodule // ttssl_backplane_model
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ttssl_pkg::*;
  logic mclk, rstn, run, bp_level, rx_level, other_irq_pending;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic tx_clock_in, tx_sync_pin_out, tx_sync_pin_oe, backplane_tx_serial, rx_loop_serial;
  logic tx_line_data, tx_clock_loss_pin, highspeed_clock_rate_sel, host_alert_n;
  logic [7:0] rd_d;
  int error_cnt = 0;
  int n_checks = 0;
  int ones;
  ttssl_backplane_model bp (.run, .bp_level, .rx_level, .tx_clock_in, .backplane_tx_serial,
    .rx_loop_serial);
  ttssl_core #(.AXI_ADDR_W(12), .TXCLK_PERIOD_NS(160)) dut (.mclk, .rstn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_clock_in,
    .tx_sync_pin_in(1'b0), .tx_sync_pin_out, .tx_sync_pin_oe, .highspeed_sync_pin(1'b0),
    .backplane_tx_serial, .rx_loop_serial, .tx_line_data, .tx_clock_loss_pin,
    .highspeed_clock_rate_sel, .other_irq_pending, .host_alert_n);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    @(posedge mclk);
    s_axi_awaddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask
  task automatic rd(input logic [IDX_W-1:0] i);
    @(posedge mclk);
    s_axi_araddr <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rd_d = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
  endtask
  task automatic rchk(input string nm, input logic [IDX_W-1:0] i, input logic [7:0] e);
    rd(i);
    chk(nm, e, rd_d);
    chk("read_resp", {6'h00, RESP_OKAY}, {6'h00, rsp});
  endtask
  task automatic count_ones(input int cyc, input bit sync_lo);
    ones = 0;
    repeat (cyc) begin
      @(posedge mclk);
      if (sync_lo ? tx_sync_pin_out === 1'b0 : tx_line_data === 1'b1) ones++;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge mclk);
    error_cnt++;
    close_out();
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rx_level, other_irq_pending} = '0;
    s_axi_wstrb = 4'hF;
    run = 1'b1;
    bp_level = 1'b1;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    repeat (6) @(posedge mclk);
    rchk("latched", IDX_TX_LATCHED_STATUS, 8'h00);
    rchk("mask", IDX_TX_INTERRUPT_MASK, 8'h00);
    rchk("config", IDX_TX_IO_CONFIG, 8'h00);
    chk("alert", 8'h01, {7'h00, host_alert_n});
    rd(10'h000);
    chk("unmapped_rd", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    wr(10'h000, 8'hFF);
    chk("unmapped_wr", {6'h00, RESP_SLVERR}, {6'h00, rsp});
    wr(IDX_TX_INTERRUPT_MASK, 8'hFF);
    rchk("mask_used", IDX_TX_INTERRUPT_MASK, STATUS_USED);
    for (int k = 0; k < 3; k++) begin
      rchk("loop_rst", IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'h00);
      wr(IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'h5A ^ 8'(k));
      rchk("loop_rw", IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'h5A ^ 8'(k));
      // Loopback off again, so that later tests see no zero runs from receive data.
      wr(IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'h00);
    end
    wr(IDX_TX_IO_CONFIG, 8'h14);
    repeat (3) @(posedge mclk);
    chk("rate_sel", 8'h01, {7'h00, highspeed_clock_rate_sel});
    chk("sync_oe", 8'h01, {7'h00, tx_sync_pin_oe});
    wr(IDX_TX_IO_CONFIG, 8'h00);
    repeat (3) @(posedge mclk);
    chk("sync_oe_off", 8'h00, {7'h00, tx_sync_pin_oe});
    $display("test registers done");
    wr(IDX_TX_CONTROL, 8'h01);
    wr(IDX_TX_INTERRUPT_MASK, 8'h03);
    wr(IDX_TX_LATCHED_STATUS, 8'hFF);
    run <= 1'b0;
    repeat (100) @(posedge mclk);
    chk("loss_pin", 8'h01, {7'h00, tx_clock_loss_pin});
    chk("alert_loss", 8'h00, {7'h00, host_alert_n});
    rd(IDX_TX_REALTIME_STATUS);
    chk("realtime", 8'h01, {7'h00, rd_d[0]});
    rchk("latched_loss", IDX_TX_LATCHED_STATUS, 8'h01);
    wr(IDX_TX_LATCHED_STATUS, 8'h01);
    repeat (3) @(posedge mclk);
    rchk("latched_clr", IDX_TX_LATCHED_STATUS, 8'h00);
    chk("loss_pin_held", 8'h01, {7'h00, tx_clock_loss_pin});
    chk("alert_clr", 8'h01, {7'h00, host_alert_n});
    run <= 1'b1;
    repeat (40) @(posedge mclk);
    rchk("restored", IDX_TX_LATCHED_STATUS, 8'h02);
    chk("loss_pin_off", 8'h00, {7'h00, tx_clock_loss_pin});
    chk("alert_rest", 8'h00, {7'h00, host_alert_n});
    wr(IDX_TX_LATCHED_STATUS, 8'h00);
    rchk("zero_write", IDX_TX_LATCHED_STATUS, 8'h02);
    wr(IDX_TX_LATCHED_STATUS, 8'h02);
    repeat (3) @(posedge mclk);
    chk("alert_free", 8'h01, {7'h00, host_alert_n});
    other_irq_pending <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("alert_other", 8'h00, {7'h00, host_alert_n});
    other_irq_pending <= 1'b0;
    $display("test clock loss done");
    wr(IDX_TX_INTERRUPT_MASK, 8'h00);
    for (int k = 0; k < 3; k++) wr(IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'hFF);
    rx_level <= 1'b1;
    bp_level <= 1'b0;
    count_ones(6176, 1'b0);
    chk("loop_all", 8'h01, {7'h00, ones > 6000});
    for (int k = 0; k < 3; k++) wr(IDX_CHAN_LOOPBACK_LO + IDX_W'(k), 8'h00);
    count_ones(6176, 1'b0);
    chk("loop_none", 8'h01, {7'h00, ones < 200});
    rd(IDX_TX_LATCHED_STATUS);
    chk("density", 8'h01, {7'h00, rd_d[ST_DENSITY]});
    chk("alert_masked", 8'h01, {7'h00, host_alert_n});
    bp_level <= 1'b1;
    $display("test loopback done");
    wr(IDX_TX_CONTROL, 8'h04);
    wr(IDX_TX_LATCHED_STATUS, 8'hFF);
    wr(IDX_TX_IO_CONFIG, 8'h46);
    repeat (20) @(posedge mclk);
    // Six frames hold six one-bit pulses plus one extra bit in the signaling frame.
    count_ones(18528, 1'b1);
    chk("sync_double", 8'h70, 8'(ones > 255 ? 255 : ones));
    wr(IDX_TX_IO_CONFIG, 8'h45);
    repeat (20) @(posedge mclk);
    count_ones(37056, 1'b1);
    chk("sync_mf", 8'h10, 8'(ones > 255 ? 255 : ones));
    $display("test sync done");
    rd(IDX_TX_LATCHED_STATUS);
    chk("multiframe", 8'h01, {7'h00, rd_d[ST_MULTIFRAME]});
    $display("test multiframe done");
    wr(IDX_TX_CONTROL, 8'h06);
    wr(IDX_TX_IO_CONFIG, 8'h28);
    wr(IDX_TX_LATCHED_STATUS, 8'hFF);
    repeat (40) @(posedge mclk);
    rd(IDX_TX_LATCHED_STATUS);
    chk("hs_align", 8'h14, rd_d & 8'h14);
    wr(IDX_TX_IO_CONFIG, 8'h08);
    wr(IDX_TX_LATCHED_STATUS, 8'hFF);
    repeat (40) @(posedge mclk);
    rd(IDX_TX_LATCHED_STATUS);
    chk("hs_plain", 8'h00, rd_d & 8'h14);
    $display("test highspeed sync done");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
